// >>> inc/hdrc_pkg.sv
// hdrc package: register map, reset values, compander knees and exposure limits
package hdrc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int CODE_W = 12;
  localparam int PIX_W = 12;
  localparam int ADDR_W = 8;
  localparam int REG_W = 16;
  localparam int COMB_W = 17;
  localparam int FIFO_DEPTH = 16;
  localparam int CREDIT_MARGIN = 4;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RATIO = 8'h04;
  localparam logic [7:0] OFF_RATIO_ALT = 8'h08;
  localparam logic [7:0] OFF_LONG_REQ = 8'h0C;
  localparam logic [7:0] OFF_FRAME_LINES = 8'h10;
  localparam logic [7:0] OFF_EFF_LONG = 8'h14;
  localparam logic [7:0] OFF_EFF_SHORT = 8'h18;
  localparam logic [7:0] OFF_MAX_LONG = 8'h1C;
  localparam logic [7:0] OFF_MIN_LONG = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_MOTION_CNT = 8'h28;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_COMPAND_BIT = 0;
  localparam int CTRL_HDR_BIT = 1;
  localparam int CTRL_ALT_CTX_BIT = 2;
  localparam int CTRL_MOTION_BIT = 14;
  localparam logic [15:0] CTRL_WMASK = 16'h4007;
  localparam int RATIO_LSB = 2;
  localparam logic [15:0] CTRL_RST = 16'h0003;
  localparam logic [1:0] RATIO_RST = 2'h2;
  localparam logic [15:0] LONG_REQ_RST = 16'h0100;
  localparam logic [15:0] FRAME_LINES_RST = 16'h0465;

  // ****************************************
  // exposure limits
  // ****************************************
  localparam logic [15:0] LINE_BUFS = 16'h0046;
  localparam logic [15:0] HDR_MARGIN = 16'h0047;
  localparam logic [15:0] LIN_MARGIN = 16'h0001;
  localparam logic [2:0] RATIO_SH_BASE = 3'h2;

  // ****************************************
  // combination and motion
  // ****************************************
  localparam logic [11:0] LONG_SAT = 12'hFC0;
  localparam logic [16:0] MC_THRESH = 17'h00400;

  // ****************************************
  // compander knees
  // ****************************************
  localparam logic [15:0] KNEE1 = 16'h0400;
  localparam logic [15:0] KNEE2 = 16'h1000;
  localparam logic [15:0] KNEE3 = 16'h8000;
  localparam logic [11:0] OUT_KNEE1 = 12'h400;
  localparam logic [11:0] OUT_KNEE2 = 12'hA00;
  localparam logic [11:0] OUT_KNEE3 = 12'hD80;
  localparam logic [11:0] OUT_MAX = 12'hF7F;
  localparam int SEG2_SH = 1;
  localparam int SEG3_SH = 5;
  localparam int SEG4_SH = 6;

  typedef enum logic [1:0] {
    HDRC_R4X = 2'b00,
    HDRC_R8X = 2'b01,
    HDRC_R16X = 2'b10,
    HDRC_R32X = 2'b11
  } hdrc_ratio_e;

endpackage

// >>> inc/hdrc_stream_if.sv
// hdrc stream carrier: valid, ready and data between pipeline stages
`timescale 1ns/1ps
interface hdrc_stream_if #(parameter int W = 16) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/hdrc_compander.sv
// hdrc compander: four-segment 16-to-12 bit compression stage with bypass
`timescale 1ns/1ps
module hdrc_compander import hdrc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic compand_en,
  // streams
  hdrc_stream_if.snk pin,
  hdrc_stream_if.src pout
);

  typedef struct packed {
    logic v;
    logic [DATA_W-1:0] d;
  } hdrc_cmp_s;

  hdrc_cmp_s q;
  hdrc_cmp_s n;

  function automatic logic [CODE_W-1:0] compand(input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] t;
    t = '0;
    if (x < KNEE1)
      compand = x[CODE_W-1:0];
    else if (x < KNEE2)
    begin
      t = (x - KNEE1) >> SEG2_SH;
      compand = t[CODE_W-1:0] + OUT_KNEE1;
    end
    else if (x < KNEE3)
    begin
      // divide by 32 above second knee
      t = (x - KNEE2) >> SEG3_SH;
      compand = t[CODE_W-1:0] + OUT_KNEE2;
    end
    else
    begin
      // divide by 64 above third knee
      t = (x - KNEE3) >> SEG4_SH;
      compand = t[CODE_W-1:0] + OUT_KNEE3;
    end
  endfunction

  // flow is held by the upstream credit check
  assign pin.ready = 1'b1;
  assign pout.valid = q.v;
  assign pout.data = q.d;

  always_comb
  begin
    n = q;
    n.v = pin.valid;
    if (pin.valid)
      n.d = compand_en ? {{(DATA_W - CODE_W){1'b0}}, compand(pin.data)} : pin.data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_seg_identity: assert property (
    pin.valid && compand_en && pin.data < KNEE1 |=> q.v && q.d == $past(pin.data))
    else $error("low segment code differs from input");
  chk_seg_half: assert property (
    pin.valid && compand_en && pin.data >= KNEE1 && pin.data < KNEE2
    |=> q.d == 16'(($past(pin.data) - KNEE1) / 2 + 16'h0400))
    else $error("second segment code wrong");
  chk_seg_top: assert property (
    pin.valid && compand_en && pin.data >= KNEE3
    |=> q.d >= 16'h0D80 && q.d <= 16'h0F7F)
    else $error("top segment code out of range");
  chk_seg_third: assert property (
    pin.valid && compand_en && pin.data >= KNEE2 && pin.data < KNEE3
    |=> q.d >= 16'h0A00 && q.d <= 16'h0D7F)
    else $error("third segment code out of range");
  chk_bypass_path: assert property (
    pin.valid && !compand_en |=> q.v && q.d == $past(pin.data))
    else $error("bypass altered data");
  cov_seg_top: cover property (pin.valid && compand_en && pin.data == 16'hFFFF);
  cov_bypass: cover property (pin.valid && !compand_en);

endmodule

// >>> rtl/hdrc_fifo.sv
// hdrc fifo: parameterised buffer with registered output word
`timescale 1ns/1ps
module hdrc_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // streams
  hdrc_stream_if.snk s,
  hdrc_stream_if.src m,
  // fill level including output word
  output logic [AW:0] level
);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } hdrc_fifo_s;

  hdrc_fifo_s q;
  hdrc_fifo_s n;
  logic push;
  logic pop;

  assign s.ready = (q.cnt != (AW + 1)'(DEPTH));
  assign m.valid = q.ov;
  assign m.data = q.od;
  assign level = q.cnt + {{AW{1'b0}}, q.ov};
  assign push = s.valid && s.ready;
  assign pop = (q.cnt != '0) && (!q.ov || m.ready);

  always_comb
  begin
    n = q;
    if (q.ov && m.ready)
      n.ov = 1'b0;
    if (pop)
    begin
      n.od = q.mem[q.rp];
      n.ov = 1'b1;
      n.rp = q.rp + AW'(1);
    end
    if (push)
    begin
      n.mem[q.wp] = s.data;
      n.wp = q.wp + AW'(1);
    end
    n.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

endmodule

// >>> rtl/hdrc_top.sv
// hdrc top: exposure combination, limits, pre-shift, compander, fifo and registers
// Operation
// - The compander takes 16-bit linearized values and yields 12-bit codes in four segments.
// - Values to 1023 pass unchanged; 1024 to 4095 become half the excess over 1024 plus 1024.
// - Data is shifted to a full 16-bit range before the compander, knees fixed for all ratios.
// - A two-bit ratio field and its alternate-context copy select the ratio, 2 meaning 16x.
// - Seventy line buffers limit the long exposure to 70 times the ratio.
// - Beyond that limit the short exposure stays at 70 rows and the true ratio is used.
// - The longest exposure is frame lines less 1 linear, less 71 in HDR, and the buffer limit.
// - The shortest exposure is one row linear and half the ratio in HDR.
// - With its enable set, motion logic detects movement and corrects ghosting.
// - Both exposures of a pixel are combined into one linearized 16-bit value; in linear mode the code uses the long exposure alone.
// - The compander works only when enabled, otherwise 16-bit data bypasses it.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module hdrc_top import hdrc_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_W-1:0] reg_rdata,
  // exposure pair input
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [PIX_W-1:0] long_exposure,
  input wire logic [PIX_W-1:0] short_exposure,
  // pixel output
  output logic out_valid,
  input wire logic out_ready,
  output logic [DATA_W-1:0] out_data
);

  localparam int LW = $clog2(DEPTH) + 1;

  if (DEPTH <= CREDIT_MARGIN)
  begin : g_bad_depth
    $error("fifo depth too small for the input credit margin");
  end

  typedef struct packed {
    logic [REG_W-1:0] ctrl;
    logic [1:0] exposure_ratio_field;
    logic [1:0] exposure_ratio_field_alt_context;
    logic [REG_W-1:0] long_req;
    logic [REG_W-1:0] frame_lines;
    logic [REG_W-1:0] eff_long;
    logic [REG_W-1:0] eff_short;
    logic [REG_W-1:0] max_long;
    logic [REG_W-1:0] min_long;
    logic [REG_W-1:0] motion_cnt;
    logic s1_v;
    logic [DATA_W-1:0] s1_d;
    logic in_ready;
    logic [REG_W-1:0] rdata;
  } hdrc_top_s;

  hdrc_top_s q;
  hdrc_top_s n;
  logic [LW-1:0] level;

  // ****************************************
  // pipeline stages
  // ****************************************
  hdrc_stream_if #(.W(DATA_W)) s1_if ();
  hdrc_stream_if #(.W(DATA_W)) cmp_if ();
  hdrc_stream_if #(.W(DATA_W)) out_if ();

  assign s1_if.valid = q.s1_v;
  assign s1_if.data = q.s1_d;
  assign out_if.ready = out_ready;
  assign out_valid = out_if.valid;
  assign out_data = out_if.data;
  assign in_ready = q.in_ready;
  assign reg_rdata = q.rdata;

  hdrc_compander u_cmp (
    .clk(clk),
    .rst(rst),
    .compand_en(q.ctrl[CTRL_COMPAND_BIT]),
    .pin(s1_if),
    .pout(cmp_if)
  );

  hdrc_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .s(cmp_if),
    .m(out_if),
    .level(level)
  );

  // ****************************************
  // exposure limits and combination
  // ****************************************
  hdrc_ratio_e ratio;
  logic hdr;
  logic [2:0] sh;
  logic [15:0] buf_lim;
  logic [15:0] frame_max;
  logic [15:0] min_l;
  logic [15:0] eff_l;
  logic over_q;
  logic [27:0] prod;
  logic [27:0] quot;
  logic [16:0] scaled;
  logic [16:0] longx;
  logic [16:0] diff;
  logic moved;
  logic [16:0] combined;
  logic [18:0] pre;
  logic [15:0] sat;
  logic accept;

  always_comb
  begin
    n = q;
    hdr = q.ctrl[CTRL_HDR_BIT];
    ratio = hdrc_ratio_e'(q.ctrl[CTRL_ALT_CTX_BIT] ? q.exposure_ratio_field_alt_context
                                                   : q.exposure_ratio_field);
    sh = RATIO_SH_BASE + {1'b0, ratio};
    buf_lim = LINE_BUFS << sh;
    if (hdr)
      frame_max = (q.frame_lines > HDR_MARGIN) ? q.frame_lines - HDR_MARGIN : '0;
    else
      frame_max = (q.frame_lines > LIN_MARGIN) ? q.frame_lines - LIN_MARGIN : '0;
    min_l = hdr ? ((16'h0001 << sh) >> 1) : 16'h0001;
    eff_l = (q.long_req > frame_max) ? frame_max : q.long_req;
    if (eff_l < min_l)
      eff_l = min_l;
    n.eff_long = eff_l;
    n.min_long = min_l;
    // reported maximum adds the buffer bound
    n.max_long = (hdr && buf_lim < frame_max) ? buf_lim : frame_max;
    // short exposure held at buffer count past the HDR buffer limit
    if (!hdr)
      n.eff_short = eff_l;
    else if (eff_l > buf_lim)
      n.eff_short = LINE_BUFS;
    else if ((eff_l >> sh) == '0)
      n.eff_short = 16'h0001;
    else
      n.eff_short = eff_l >> sh;

    // actual ratio used once past the buffer limit
    over_q = hdr && (q.eff_long > buf_lim);
    prod = {16'h0000, short_exposure} * {12'h000, q.eff_long};
    quot = prod / {12'h000, LINE_BUFS};
    if (over_q)
      scaled = (quot > 28'h001FFFF) ? 17'h1FFFF : quot[16:0];
    else
      scaled = {5'h00, short_exposure} << sh;
    longx = {5'h00, long_exposure};
    diff = (longx > scaled) ? longx - scaled : scaled - longx;
    // motion picks the short exposure to avoid ghosts
    moved = q.ctrl[CTRL_MOTION_BIT] && hdr && (long_exposure < LONG_SAT) && (diff > MC_THRESH);
    combined = ((long_exposure >= LONG_SAT) || moved) ? scaled : longx;
    // pre-shift to the full 16-bit range
    if (!hdr)
      pre = {3'h0, long_exposure, 4'h0};
    else
    begin
      unique case (ratio)
        HDRC_R4X: pre = {2'h0, combined} << 2;
        HDRC_R8X: pre = {2'h0, combined} << 1;
        HDRC_R16X: pre = {2'h0, combined};
        HDRC_R32X: pre = {2'h0, combined} >> 1;
      endcase
    end
    sat = (|pre[18:16]) ? 16'hFFFF : pre[15:0];

    accept = in_valid && q.in_ready;
    n.s1_v = accept;
    if (accept)
      n.s1_d = sat;
    if (accept && moved && q.motion_cnt != 16'hFFFF)
      n.motion_cnt = q.motion_cnt + 16'h0001;
    // worst case four words in flight once ready is seen
    n.in_ready = (level <= LW'(DEPTH - CREDIT_MARGIN));

    // ****************************************
    // register port
    // ****************************************
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFF_CTRL: n.ctrl = reg_wdata & CTRL_WMASK;
        OFF_RATIO: n.exposure_ratio_field = reg_wdata[RATIO_LSB +: 2];
        OFF_RATIO_ALT: n.exposure_ratio_field_alt_context = reg_wdata[RATIO_LSB +: 2];
        OFF_LONG_REQ: n.long_req = reg_wdata;
        OFF_FRAME_LINES: n.frame_lines = reg_wdata;
        default: ;
      endcase
    end
    n.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFF_CTRL: n.rdata = q.ctrl;
        OFF_RATIO: n.rdata = {12'h000, q.exposure_ratio_field, 2'h0};
        OFF_RATIO_ALT: n.rdata = {12'h000, q.exposure_ratio_field_alt_context, 2'h0};
        OFF_LONG_REQ: n.rdata = q.long_req;
        OFF_FRAME_LINES: n.rdata = q.frame_lines;
        OFF_EFF_LONG: n.rdata = q.eff_long;
        OFF_EFF_SHORT: n.rdata = q.eff_short;
        OFF_MAX_LONG: n.rdata = q.max_long;
        OFF_MIN_LONG: n.rdata = q.min_long;
        OFF_STATUS: n.rdata = {q.in_ready, {(REG_W - 1 - LW){1'b0}}, level};
        OFF_MOTION_CNT: n.rdata = q.motion_cnt;
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.exposure_ratio_field <= RATIO_RST;
      q.exposure_ratio_field_alt_context <= RATIO_RST;
      q.long_req <= LONG_REQ_RST;
      q.frame_lines <= FRAME_LINES_RST;
    end
    else
      q <= n;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_short_cap: assert property (
    hdr && eff_l > buf_lim |=> q.eff_short == 16'h0046)
    else $error("short exposure not held at buffer count");
  chk_frame_bound: assert property (
    hdr && q.frame_lines > 16'h0047 && $stable(q.frame_lines) && $stable(q.ctrl)
    |=> q.max_long <= q.frame_lines - 16'h0047 && q.eff_long <= q.frame_lines - 16'h0047)
    else $error("long exposure above frame bound");
  chk_min_linear: assert property (
    !hdr && $stable(q.ctrl) |=> q.min_long == 16'h0001)
    else $error("linear minimum not one row");
  chk_min_ratio16: assert property (
    hdr && ratio == HDRC_R16X |=> q.min_long == 16'h0008)
    else $error("hdr minimum not half the ratio");
  chk_ratio_code: assert property (
    hdr && ratio == HDRC_R16X && !over_q && long_exposure >= LONG_SAT && in_valid && q.in_ready
    |=> q.s1_v && q.s1_d == {$past(short_exposure), 4'h0})
    else $error("16x scaling wrong");
  chk_shift_4x: assert property (
    hdr && ratio == HDRC_R4X && !moved && long_exposure < LONG_SAT && accept
    |=> q.s1_d == {2'h0, $past(long_exposure), 2'h0})
    else $error("4x pre-shift wrong");
  chk_no_overflow: assert property (
    cmp_if.valid |-> cmp_if.ready)
    else $error("fifo overflow");
  chk_read_latency: assert property (
    reg_rd && reg_addr == OFF_EFF_SHORT ##1 1'b1 |-> reg_rdata == $past(q.eff_short))
    else $error("read data not one cycle later");
  chk_motion_count: assert property (
    accept && moved && q.motion_cnt != 16'hFFFF |=> q.motion_cnt == $past(q.motion_cnt) + 16'h0001)
    else $error("motion event not counted");
  cov_over_limit: cover property (over_q && accept);
  cov_motion: cover property (accept && moved);
  cov_backpressure: cover property (!q.in_ready && in_valid);

endmodule

// >>> test/hdrc_isp_model.sv
// hdrc isp model: takes companded words, relinearizes and unshifts them
`timescale 1ns/1ps
module hdrc_isp_model import hdrc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pixel stream from the sensor
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [DATA_W-1:0] out_data,
  // bench control
  input wire logic hold,
  input wire logic slow,
  input wire logic [1:0] ratio,
  // received word
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_word,
  output logic [DATA_W:0] rx_lin
);
  // ****************************************
  // receive and relinearize
  // ****************************************
  logic [1:0] cnt_q;
  logic [DATA_W-1:0] dec;
  logic [DATA_W:0] lin;

  // slow mode stalls one cycle in four
  assign out_ready = !hold && !(slow && cnt_q == 2'h0);

  always_comb
  begin
    if (out_data < 16'h0400)
      dec = out_data;
    else if (out_data < 16'h0A00)
      dec = ((out_data - 16'h0400) << 1) + 16'h0400;
    else if (out_data < 16'h0D80)
      dec = ((out_data - 16'h0A00) << 5) + 16'h1000;
    else
      dec = ((out_data - 16'h0D80) << 6) + 16'h8000;
  end

  always_comb
  begin
    case (ratio)
      HDRC_R4X: lin = {1'b0, dec} >> 2;
      HDRC_R8X: lin = {1'b0, dec} >> 1;
      HDRC_R16X: lin = {1'b0, dec};
      default: lin = {dec, 1'b0};
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 2'h0;
      rx_valid <= 1'b0;
      rx_word <= 16'h0000;
      rx_lin <= 17'h00000;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      rx_valid <= out_valid & out_ready;
      rx_word <= out_data;
      rx_lin <= lin;
    end
  end
endmodule

// >>> test/hdrc_tb_top.sv
// hdrc testbench: registers, compander, exposure limits, motion and fifo
`timescale 1ns/1ps
module hdrc_tb_top import hdrc_pkg::*; ;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [REG_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [REG_W-1:0] reg_rdata;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [PIX_W-1:0] long_exposure = '0;
  logic [PIX_W-1:0] short_exposure = '0;
  logic out_valid;
  logic out_ready;
  logic [DATA_W-1:0] out_data;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic [1:0] ratio = 2'h2;
  logic rx_valid;
  logic [DATA_W-1:0] rx_word;
  logic [DATA_W:0] rx_lin;
  logic [DATA_W:0] lx;
  logic saw_full = 1'b0;
  logic [DATA_W-1:0] expq[$];
  logic [DATA_W:0] linq[$];
  logic [PIX_W-1:0] lin_set[7] = '{12'h03F, 12'h040, 12'h0FF, 12'h100, 12'h7FF, 12'h800, 12'hFFF};
  int error_cnt = 0;
  int tests_run = 0;

  always #50 clk = ~clk;

  hdrc_top #(.DEPTH(16)) u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .long_exposure(long_exposure),
    .short_exposure(short_exposure), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));

  hdrc_isp_model u_isp (.clk(clk), .rst(rst), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .hold(hold), .slow(slow), .ratio(ratio), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_lin(rx_lin));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata, exp);
  endtask

  function automatic logic [15:0] comp_code(input logic [15:0] v, input logic en);
    if (!en) return v;
    if (v < 16'h0400) return v;
    if (v < 16'h1000) return ((v - 16'h0400) >> 1) + 16'h0400;
    if (v < 16'h8000) return ((v - 16'h1000) >> 5) + 16'h0A00;
    return ((v - 16'h8000) >> 6) + 16'h0D80;
  endfunction

  task automatic send(input logic [PIX_W-1:0] l, input logic [PIX_W-1:0] s,
    input logic [15:0] exp, input logic [DATA_W:0] lin = '0);
    int n;
    n = 0;
    in_valid <= 1'b1;
    long_exposure <= l;
    short_exposure <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (in_ready !== 1'b1 && n < 200);
    if (n >= 200) error_cnt++;
    expq.push_back(exp);
    linq.push_back(lin);
  endtask

  task automatic drain;
    int n;
    n = 0;
    in_valid <= 1'b0;
    while (expq.size() != 0 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) error_cnt++;
  endtask

  task automatic complete_run;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // scoreboard and monitors
  // ****************************************
  always @(posedge clk)
  begin
    if (in_valid === 1'b1 && in_ready === 1'b0 && rst === 1'b0) saw_full <= 1'b1;
    if (rx_valid === 1'b1)
    begin
      if (expq.size() == 0) error_cnt++;
      else
      begin
        chk(rx_word, expq.pop_front());
        lx = linq.pop_front();
        if (lx[DATA_W]) chk(rx_lin[DATA_W-1:0], lx[DATA_W-1:0]);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run;
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_RATIO, 16'h0008);
    rd(OFF_RATIO_ALT, 16'h0008);
    rd(OFF_LONG_REQ, LONG_REQ_RST);
    rd(OFF_FRAME_LINES, FRAME_LINES_RST);
    rd(OFF_EFF_LONG, 16'h0100);
    rd(OFF_EFF_SHORT, 16'h0010);
    rd(OFF_MIN_LONG, 16'h0008);
    wr(OFF_MAX_LONG, 16'h0000);
    rd(OFF_MAX_LONG, 16'h041E);
    rd(8'hFC, 16'h0000);
    $display("test registers done");
    for (int m = 1; m >= 0; m--)
    begin
      wr(OFF_CTRL, 16'(m));
      foreach (lin_set[i]) send(lin_set[i], 12'h000, comp_code({lin_set[i], 4'h0}, m[0]));
      drain;
    end
    rd(OFF_MIN_LONG, 16'h0001);
    $display("test linear compander done");
    wr(OFF_CTRL, 16'h0003);
    for (int r = 0; r < 4; r++)
    begin
      wr(OFF_RATIO, 16'(r << 2));
      ratio <= 2'(r);
      rd(OFF_MIN_LONG, 16'(2 << r));
      rd(OFF_MAX_LONG, (16'(280 << r) < 16'h041E) ? 16'(280 << r) : 16'h041E);
      send(12'hFFF, 12'h0A5, comp_code(16'h0A50, 1'b1), {1'b1, 16'h00A5 << (2+r)});
      send(12'hFFF, 12'hFFF, comp_code(16'hFFF0, 1'b1));
      send(12'h800, 12'h000, comp_code(16'h8000 >> (2 + r), 1'b1), 17'h10800);
      drain;
    end
    wr(OFF_RATIO_ALT, 16'h0000);
    wr(OFF_CTRL, 16'h0007);
    rd(OFF_MIN_LONG, 16'h0002);
    $display("test ratios done");
    wr(OFF_CTRL, 16'h0003);
    wr(OFF_RATIO, 16'h0004);
    ratio <= 2'h1;
    wr(OFF_LONG_REQ, 16'h0400);
    rd(OFF_EFF_SHORT, 16'h0046);
    rd(OFF_EFF_LONG, 16'h0400);
    rd(OFF_MAX_LONG, 16'h0230);
    send(12'hFFF, 12'h046, 16'h0600, 17'h10400);
    drain;
    wr(OFF_LONG_REQ, 16'h0100);
    $display("test buffer limit done");
    wr(OFF_RATIO, 16'h0008);
    ratio <= 2'h2;
    wr(OFF_CTRL, 16'h4003);
    send(12'h010, 12'h0FF, comp_code(16'h0FF0, 1'b1), 17'h10FF0);
    drain;
    rd(OFF_MOTION_CNT, 16'h0001);
    $display("test motion done");
    wr(OFF_CTRL, 16'h0003);
    hold <= 1'b1;
    fork
      begin
        repeat (80) @(posedge clk);
        hold <= 1'b0;
        slow <= 1'b1;
      end
    join_none
    for (int i = 0; i < 24; i++) send(12'hFFF, 12'(i), comp_code(16'(i << 4), 1'b1));
    drain;
    chk({15'h0000, saw_full}, 16'h0001);
    rd(OFF_STATUS, 16'h8000);
    $display("test fifo done");
    complete_run;
  end
endmodule
